// ===== hdl/qdac_cfg.svh
`ifndef QDAC_CFG_SVH
`define QDAC_CFG_SVH

// ****************************************************************
// serial word layout
// ****************************************************************
`define QDAC_WORD_BITS 16
`define QDAC_LAST_BIT 4'hF
`define QDAC_CHAN_HI 15
`define QDAC_CHAN_LO 14
`define QDAC_POWER_ON_BIT 13
`define QDAC_LOAD_ALL_BIT 12
`define QDAC_CODE_MSB 11
`define QDAC_CODE_MAX 12
`define QDAC_RES_DEF 12

// ****************************************************************
// timing
// ****************************************************************
`define QDAC_CLK_PERIOD_NS 4
`define QDAC_PWRUP_5V_NS 5000
`define QDAC_PWRUP_3V_NS 2500
`define QDAC_PWRUP_5V_CYC ((`QDAC_PWRUP_5V_NS + `QDAC_CLK_PERIOD_NS - 1) / `QDAC_CLK_PERIOD_NS)
`define QDAC_PWRUP_3V_CYC ((`QDAC_PWRUP_3V_NS + `QDAC_CLK_PERIOD_NS - 1) / `QDAC_CLK_PERIOD_NS)
`define QDAC_PWR_CNT_W 11

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define QDAC_ADDR_W 6
`define QDAC_OFS_CTRL 6'h00
`define QDAC_OFS_STATUS 6'h04
`define QDAC_OFS_LAST 6'h08
`define QDAC_SEL_DAC 2'h1
`define QDAC_SEL_INPUT 2'h2
`define QDAC_CTRL_SUPPLY_5V 0
`define QDAC_CTRL_RESET 32'h0000_0001
`define QDAC_ST_VALID 0
`define QDAC_ST_HIZ 1
`define QDAC_ST_BUSY 2
`define QDAC_ST_ABORT 3

`endif

// ===== hdl/qdac_pkg.sv
package qdac_pkg;

    typedef struct packed {
        logic sync_n;
        logic sclk;
        logic din;
    } qdac_link_t;

    typedef struct packed {
        logic [3:0][11:0] code;
    } qdac_codes_t;

    typedef enum logic [2:0] {
        QDAC_IDLE = 3'h1,
        QDAC_SHIFT = 3'h2,
        QDAC_DONE = 3'h4
    } qdac_state_t;

endpackage

// ===== hdl/qdac_sync.sv
`timescale 1ns/1ps

module qdac_sync #(
    parameter int W = 3
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // idle link level is all ones (frame select high, clock high)
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '1;
            q <= '1;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ===== hdl/qdac_top.sv
`timescale 1ns/1ps
`include "qdac_cfg.svh"
// Functional notes
// [R1] 16-bit register shifts data on falling clock
// [R2] frame select low starts sixteen-edge capture
// [R3] early frame select rise aborts, discards word
// [R4] completed word ignores further clock and data
// [R5] host keeps serial clock at most 30 MHz
// [R6] power-on clears all channels to zero
// [R7] one write can update all four channels
// [R8] outputs valid after power-up delay only; reset sets outputs_valid high at once, with no delay
// [R9] resolution 8, 10 or 12 by parameter
// [R10] msb first, top two bits pick channel
// [R11] bit 13 low powers down, outputs hiz
// [R12] bit 12 low loads all channel registers
// [R13] code left-aligned, low bits dropped when narrow
// [R14] after word, wait frame select high then low
// [R15] input register written only on full frame
module qdac_top #(
    parameter int RES = `QDAC_RES_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire qdac_pkg::qdac_link_t link_pins,
    input wire logic [`QDAC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output qdac_pkg::qdac_codes_t dac_codes,
    output logic out_hiz,
    output logic outputs_valid
);
    import qdac_pkg::*;
    // ****************************************************************
    // link sampling
    // ****************************************************************
    qdac_link_t link_s;
    logic sclk_d_r;
    logic sync_d_r;
    logic sclk_fall;
    logic sync_fall;
    // [R5] host clock limit: 30 MHz leaves over 4 samples per half period
    qdac_sync #(.W($bits(qdac_link_t))) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .d(link_pins),
        .q(link_s)
    );
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sclk_d_r <= 1'b1;
            sync_d_r <= 1'b1;
        end else begin
            sclk_d_r <= link_s.sclk;
            sync_d_r <= link_s.sync_n;
        end
    end

    assign sclk_fall = sclk_d_r & ~link_s.sclk;
    assign sync_fall = sync_d_r & ~link_s.sync_n;
    // ****************************************************************
    // frame control
    // ****************************************************************
    qdac_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [15:0] shift_r;
    logic [15:0] word_nxt;
    logic commit;
    logic abort;
    logic [1:0] chan;
    logic [11:0] code_nxt;
    assign word_nxt = {shift_r[14:0], link_s.din};
    // [R15] full frame only
    assign commit = (state_r == QDAC_SHIFT) && sclk_fall && (bit_cnt_r == `QDAC_LAST_BIT);
    // [R3] early rise aborts
    assign abort = (state_r == QDAC_SHIFT) && !sclk_fall && link_s.sync_n;
    // [R10] channel from top bits
    assign chan = {word_nxt[`QDAC_CHAN_HI], word_nxt[`QDAC_CHAN_LO]};
    // [R13] keep top RES bits of the code field, right-aligned
    function automatic logic [11:0] trim_code(input logic [15:0] w);
        logic [11:0] f;
        f = w[`QDAC_CODE_MSB:0];
        trim_code = f >> (`QDAC_CODE_MAX - RES);
    endfunction
    // [R9] resolution chosen by parameter
    assign code_nxt = trim_code(word_nxt);
    // [R2] frame start and sixteen edges
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= QDAC_IDLE;
            bit_cnt_r <= 4'h0;
        end else begin
            case (state_r)
                QDAC_IDLE: begin
                    bit_cnt_r <= 4'h0;
                    if (sync_fall) begin
                        state_r <= QDAC_SHIFT;
                    end
                end
                QDAC_SHIFT: begin
                    if (commit) begin
                        state_r <= QDAC_DONE;
                    end else if (sclk_fall) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (abort) begin
                        state_r <= QDAC_IDLE;
                    end
                end
                // [R14] rearm only after frame select high
                QDAC_DONE: begin
                    if (link_s.sync_n) begin
                        state_r <= QDAC_IDLE;
                    end
                end
                default: begin
                    state_r <= QDAC_IDLE;
                end
            endcase
        end
    end
    // [R1] msb-first shift on falling clock
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shift_r <= 16'h0000;
        end else if ((state_r == QDAC_SHIFT) && sclk_fall) begin
            // [R4] input gated outside the shift state
            shift_r <= word_nxt;
        end
    end
    // ****************************************************************
    // channel registers
    // ****************************************************************
    qdac_codes_t input_r;
    qdac_codes_t dac_r;
    logic [3:0] upd_r;
    logic [15:0] last_r;
    // [R6] everything clears to code zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            input_r <= '0;
            dac_r <= '0;
            upd_r <= 4'h0;
            last_r <= 16'h0000;
        end else if (commit) begin
            last_r <= word_nxt;
            input_r.code[chan] <= code_nxt;
            // [R12] load-all bit low copies every refreshed input
            if (!word_nxt[`QDAC_LOAD_ALL_BIT]) begin
                // [R7] addressed and refreshed channels change on one edge
                for (int i = 0; i < 4; i++) begin
                    if (i == int'(chan)) begin
                        dac_r.code[i] <= code_nxt;
                    end else if (upd_r[i]) begin
                        dac_r.code[i] <= input_r.code[i];
                    end
                end
                upd_r <= 4'h0;
            end else begin
                upd_r[chan] <= 1'b1;
            end
        end
    end
    assign dac_codes = dac_r;
    // ****************************************************************
    // power state
    // ****************************************************************
    logic power_on_r;
    logic [`QDAC_PWR_CNT_W-1:0] pwr_cnt_r;
    logic valid_r;
    logic [31:0] ctrl_r;
    logic [`QDAC_PWR_CNT_W-1:0] pwr_load;
    assign pwr_load = ctrl_r[`QDAC_CTRL_SUPPLY_5V] ?
        `QDAC_PWR_CNT_W'(`QDAC_PWRUP_5V_CYC) : `QDAC_PWR_CNT_W'(`QDAC_PWRUP_3V_CYC);
    // [R11] power bit low gives high-impedance outputs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            power_on_r <= 1'b1;
        end else if (commit) begin
            power_on_r <= word_nxt[`QDAC_POWER_ON_BIT];
        end
    end
    // [R8] power-up delay, length set by supply select
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pwr_cnt_r <= '0;
        end else if (commit && word_nxt[`QDAC_POWER_ON_BIT] && !power_on_r) begin
            pwr_cnt_r <= pwr_load;
        end else if (pwr_cnt_r != '0) begin
            pwr_cnt_r <= pwr_cnt_r - `QDAC_PWR_CNT_W'(1);
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            valid_r <= 1'b1;
        end else begin
            valid_r <= power_on_r && (pwr_cnt_r == '0);
        end
    end
    assign out_hiz = ~power_on_r;
    assign outputs_valid = valid_r;
    // ****************************************************************
    // avalon slave, one wait cycle per access
    // ****************************************************************
    logic ack_r;
    logic abort_seen_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_mux;
    logic wr_go;
    function automatic logic reg_hit(input logic [5:0] a, input logic [5:0] ofs);
        reg_hit = ({a[5:2], 2'h0} == ofs);
    endfunction
    assign avs_waitrequest = ~ack_r;
    assign avs_readdata = rdata_r;
    assign wr_go = avs_write && ack_r;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address[5:4])
            `QDAC_SEL_DAC: rd_mux[11:0] = dac_r.code[avs_address[3:2]];
            `QDAC_SEL_INPUT: rd_mux[11:0] = input_r.code[avs_address[3:2]];
            default: begin
                if (reg_hit(avs_address, `QDAC_OFS_CTRL)) begin
                    rd_mux = ctrl_r;
                end else if (reg_hit(avs_address, `QDAC_OFS_STATUS)) begin
                    rd_mux[`QDAC_ST_VALID] = valid_r;
                    rd_mux[`QDAC_ST_HIZ] = ~power_on_r;
                    rd_mux[`QDAC_ST_BUSY] = (state_r == QDAC_SHIFT);
                    rd_mux[`QDAC_ST_ABORT] = abort_seen_r;
                end else if (reg_hit(avs_address, `QDAC_OFS_LAST)) begin
                    rd_mux[15:0] = last_r;
                end
            end
        endcase
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
            if (avs_read && !ack_r) begin
                rdata_r <= rd_mux;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `QDAC_CTRL_RESET;
        end else if (wr_go && avs_byteenable[0] && reg_hit(avs_address, `QDAC_OFS_CTRL)) begin
            ctrl_r[`QDAC_CTRL_SUPPLY_5V] <= avs_writedata[`QDAC_CTRL_SUPPLY_5V];
        end
    end
    // a new abort wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            abort_seen_r <= 1'b0;
        end else begin
            abort_seen_r <= abort || (abort_seen_r && !(wr_go && avs_byteenable[0]
                && reg_hit(avs_address, `QDAC_OFS_STATUS) && avs_writedata[`QDAC_ST_ABORT]));
        end
    end
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_shift_takes_din: assert property ( // [R1]
        (state_r == QDAC_SHIFT) && sclk_fall |=> shift_r[0] == $past(link_s.din))
        else $error("shift register missed the data bit");
    a_frame_start: assert property ( // [R2]
        (state_r == QDAC_IDLE) && sync_fall |=> (state_r == QDAC_SHIFT) && (bit_cnt_r == 4'h0))
        else $error("frame did not start on select fall");
    a_abort_keeps_regs: assert property ( // [R3]
        abort |=> $stable(input_r) && $stable(dac_r) && (state_r == QDAC_IDLE))
        else $error("abort changed a channel register");
    a_done_ignores_link: assert property ( // [R4]
        (state_r == QDAC_DONE) |=> $stable(shift_r) && $stable(input_r))
        else $error("link activity after a complete word");
    a_load_all_copy: assert property ( // [R12]
        commit && !word_nxt[`QDAC_LOAD_ALL_BIT] |=> dac_r.code[$past(chan)] == $past(code_nxt))
        else $error("load-all did not update the addressed channel");
    a_load_one_hold: assert property ( // [R12]
        commit && word_nxt[`QDAC_LOAD_ALL_BIT] |=> $stable(dac_r))
        else $error("channel output changed without load-all");
    a_power_hiz: assert property ( // [R11]
        commit && !word_nxt[`QDAC_POWER_ON_BIT] |=> out_hiz ##1 !outputs_valid)
        else $error("power-down word did not float outputs");
    a_pwrup_delay: assert property ( // [R8]
        commit && word_nxt[`QDAC_POWER_ON_BIT] && out_hiz |=> !outputs_valid [*8])
        else $error("outputs valid before power-up delay");
    a_commit_count: assert property ( // [R15]
        $changed(input_r) |-> $past(state_r) == QDAC_SHIFT && $past(bit_cnt_r) == 4'hF)
        else $error("input register written before sixteen edges");
    a_bus_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");
endmodule

// ===== testbench/qdac_host_model.sv
`timescale 1ns/1ps

// ****************************************************************
// host side of the serial write link
// ****************************************************************
module qdac_host_model (
    input wire logic clk_sys,
    output qdac_pkg::qdac_link_t link_pins
);
    import qdac_pkg::*;

    // clock under 30 MHz: 8 + 8 system cycles gives a 64 ns period
    localparam int HALF = 8;

    initial begin
        link_pins = '{sync_n: 1'b1, sclk: 1'b1, din: 1'b0};
    end

    // sclk stands still high between frames; din shows the inverse of its last bit
    task automatic send(input logic [15:0] word, input int nbits, input int extra);
        int i;
        @(posedge clk_sys);
        // frame select low opens the frame
        link_pins.sync_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (i = 0; i < nbits + extra; i++) begin
            // msb first; clocks past the word carry junk
            link_pins.din <= (i < nbits) ? word[15-i] : ~link_pins.din;
            link_pins.sclk <= 1'b1;
            repeat (HALF) @(posedge clk_sys);
            link_pins.sclk <= 1'b0;
            repeat (HALF) @(posedge clk_sys);
        end
        link_pins.din <= ~link_pins.din;
        repeat (HALF) @(posedge clk_sys);
        link_pins.sync_n <= 1'b1;
        link_pins.sclk <= 1'b1;
        repeat (HALF) @(posedge clk_sys);
    endtask
endmodule

// ===== testbench/tb_quad_dac_serial_frame_input.sv
`timescale 1ns/1ps
`include "qdac_cfg.svh"

module tb_quad_dac_serial_frame_input;
    import qdac_pkg::*;

    localparam int RES = 12;
    localparam int LIMIT = 20000;

    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    qdac_link_t link_pins;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    qdac_codes_t dac_codes;
    qdac_codes_t dac_codes8;
    logic out_hiz;
    logic outputs_valid;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int s;
    int n;

    always #2 clk_sys = ~clk_sys;

    qdac_host_model u_host (.clk_sys(clk_sys), .link_pins(link_pins));

    qdac_top #(.RES(RES)) u_dut (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .link_pins(link_pins),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .dac_codes(dac_codes),
        .out_hiz(out_hiz),
        .outputs_valid(outputs_valid)
    );

    // narrow build on the same link and bus: shows the dropped low code bits
    qdac_top #(.RES(8)) u_dut_res8 (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .link_pins(link_pins),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF),
        .avs_readdata(),
        .avs_waitrequest(),
        .dac_codes(dac_codes8),
        .out_hiz(),
        .outputs_valid()
    );

    // ****************************************************************
    // checking and bus tasks
    // ****************************************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until the edge that samples waitrequest low
    task automatic bus_cycle(input logic [5:0] addr, input logic wr, input logic [31:0] wdata,
                             output logic [31:0] rdata);
        int k;
        k = 0;
        @(posedge clk_sys);
        avs_address <= addr;
        avs_writedata <= wdata;
        if (wr) begin
            avs_write <= 1'b1;
        end else begin
            avs_read <= 1'b1;
        end
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 50) begin
            chk("bus answer", 48'h1, 48'h0);
        end
    endtask

    task automatic rd_chk(input string what, input logic [5:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        bus_cycle(addr, 1'b0, 32'h0, d);
        chk(what, 48'(d), 48'(exp));
    endtask

    task automatic wr(input logic [5:0] addr, input logic [31:0] data);
        logic [31:0] d;
        bus_cycle(addr, 1'b1, data, d);
    endtask

    function automatic logic [15:0] wd(input logic [1:0] ch, input logic pon, input logic hold,
                                       input logic [11:0] code);
        return {ch, pon, hold, code};
    endfunction

    // a hang counts as a mismatch and ends the run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            end_sim();
        end
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chk("codes after reset", 48'(dac_codes), 48'h0);
        chk("valid after reset", 48'(outputs_valid), 48'h1);
        chk("hiz after reset", 48'(out_hiz), 48'h0);
        rd_chk("ctrl reset", `QDAC_OFS_CTRL, `QDAC_CTRL_RESET);
        rd_chk("status reset", `QDAC_OFS_STATUS, 32'h1);
        rd_chk("unmapped", 6'h30, 32'h0);
        // input registers only: dac side must stay at zero
        for (s = 0; s < 3; s++) begin
            u_host.send(wd(2'(s), 1'b1, 1'b1, 12'hA50 + 12'(s)), 16, 0);
            rd_chk("input reg", 6'h20 + 6'(4 * s), 32'hA50 + 32'(s));
            rd_chk("last word", `QDAC_OFS_LAST, 32'(wd(2'(s), 1'b1, 1'b1, 12'hA50 + 12'(s))));
            chk("codes held", 48'(dac_codes), 48'h0);
        end
        // short frame is dropped, abort flag sticky until cleared
        u_host.send(wd(2'h1, 1'b1, 1'b1, 12'h123), 10, 0);
        rd_chk("input b kept", 6'h24, 32'hA51);
        rd_chk("abort flag", `QDAC_OFS_STATUS, 32'h9);
        wr(`QDAC_OFS_STATUS, 32'h8);
        rd_chk("abort cleared", `QDAC_OFS_STATUS, 32'h1);
        // one write moves all four channels
        u_host.send(wd(2'h3, 1'b1, 1'b0, 12'hFFF), 16, 0);
        chk("load all", 48'(dac_codes), 48'hFFF_A52_A51_A50);
        chk("load all narrow", 48'(dac_codes8), 48'h0FF_0A5_0A5_0A5);
        rd_chk("dac d", 6'h1C, 32'hFFF);
        // clocks after the sixteenth fall are ignored
        u_host.send(wd(2'h0, 1'b1, 1'b1, 12'h5A5), 16, 4);
        rd_chk("input a", 6'h20, 32'h5A5);
        rd_chk("last word junk", `QDAC_OFS_LAST, 32'(wd(2'h0, 1'b1, 1'b1, 12'h5A5)));
        chk("dac a kept", 48'(dac_codes), 48'hFFF_A52_A51_A50);
        // power down, then power up under each supply setting
        for (s = 1; s >= 0; s--) begin
            n = (s == 1) ? `QDAC_PWRUP_5V_CYC : `QDAC_PWRUP_3V_CYC;
            wr(`QDAC_OFS_CTRL, 32'(s));
            u_host.send(wd(2'h0, 1'b0, 1'b1, 12'h000), 16, 0);
            chk("hiz on", 48'(out_hiz), 48'h1);
            rd_chk("status down", `QDAC_OFS_STATUS, 32'h2);
            u_host.send(wd(2'h0, 1'b1, 1'b1, 12'h111), 16, 0);
            chk("hiz off", 48'(out_hiz), 48'h0);
            chk("valid low", 48'(outputs_valid), 48'h0);
            repeat (n - 40) @(posedge clk_sys);
            chk("valid still low", 48'(outputs_valid), 48'h0);
            repeat (60) @(posedge clk_sys);
            chk("valid back", 48'(outputs_valid), 48'h1);
        end
        // reset in mid-run clears every channel again
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chk("codes after mid reset", 48'(dac_codes), 48'h0);
        chk("narrow codes after mid reset", 48'(dac_codes8), 48'h0);
        chk("valid after mid reset", 48'(outputs_valid), 48'h1);
        end_sim();
    end
endmodule
